// *** logic/qdac_map.svh ***
`ifndef QDAC_MAP_SVH
`define QDAC_MAP_SVH

`define QDAC_SHIFT_W        16
`define QDAC_WIDE_CODE_W    12
`define QDAC_NARROW_CODE_W  10
`define QDAC_WIDE_ALL_BIT   15
`define QDAC_WIDE_ONE_BIT   14
`define QDAC_WIDE_AHI_BIT   13
`define QDAC_WIDE_ALO_BIT   12
`define QDAC_NARROW_ALL_BIT 13
`define QDAC_NARROW_ONE_BIT 12
`define QDAC_NARROW_AHI_BIT 11
`define QDAC_NARROW_ALO_BIT 10
`define QDAC_RESET_CODE     16'h0000
`define QDAC_RESET_SHUT     4'h0
`define QDAC_RESET_SHIFT    16'h0000
`define QDAC_PIN_IDLE       3'h7

`endif

// *** logic/qdac_pkg.sv ***
package qdac_pkg;

    typedef enum logic [1:0] {
        QDAC_CMD_LOAD     = 2'b00,
        QDAC_CMD_SHUT_ONE = 2'b01,
        QDAC_CMD_SHUT_ALL = 2'b10
    } qdac_cmd_e;

    typedef logic [1:0] qdac_chan_t;

endpackage

// *** logic/qdac_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module qdac_sync2 #(
    parameter int          W        = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,   // destination clock
    input  wire logic         rst_n_i, // async reset, active low
    input  wire logic [W-1:0] d_i,     // asynchronous level
    output logic      [W-1:0] q_o      // synchronised level
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } qdac_sync_s;

    qdac_sync_s s_reg;
    qdac_sync_s s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.meta = d_i;
        s_next.sync = s_reg.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= {RST_VAL, RST_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.sync;
endmodule
`default_nettype wire

// *** logic/qdac_link.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "qdac_map.svh"
module qdac_link (
    input  wire logic                     sclk_i,      // serial clock from host
    input  wire logic                     rst_n_i,     // power-on reset, active low
    input  wire logic                     select_n_i,  // frame select, active low
    input  wire logic                     serial_in_i, // serial data, msb first
    output logic      [`QDAC_SHIFT_W-1:0] shift_o      // shifter contents
);
    import qdac_pkg::*;

    typedef struct packed {
        logic [`QDAC_SHIFT_W-1:0] shift;
    } qdac_link_s;

    qdac_link_s l_reg;
    qdac_link_s l_next;

    always_comb begin
        l_next = l_reg;
        if (!select_n_i) begin
            l_next.shift = {l_reg.shift[`QDAC_SHIFT_W-2:0], serial_in_i};
        end
    end

    // no zero-reset input here: the shifter survives it
    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l_reg <= `QDAC_RESET_SHIFT;
        end else begin
            l_reg <= l_next;
        end
    end

    assign shift_o = l_reg.shift;

    logic bit0;
    assign bit0 = l_reg.shift[0];

    a_shift_hold: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        select_n_i |=> $stable(l_reg.shift))
        else $error("shifter moved while select high");

    a_shift_order: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        !select_n_i |=> (l_reg.shift[0] == $past(serial_in_i)) && (l_reg.shift[1] == $past(bit0)))
        else $error("shifter did not advance one bit");
endmodule
`default_nettype wire

// *** logic/qdac_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "qdac_map.svh"
module qdac_top #(
    parameter int CODE_W = `QDAC_WIDE_CODE_W
) (
    input  wire logic                clk_i,           // system clock, 200 MHz
    input  wire logic                rst_n_i,         // power-on reset, active low
    input  wire logic                sclk_i,          // serial clock from host
    input  wire logic                select_n_i,      // frame select, active low
    input  wire logic                serial_in_i,     // serial data in
    input  wire logic                load_strobe_n_i, // DAC load level, active low
    input  wire logic                zero_reset_n_i,  // zero-code reset, active low
    output logic      [4*CODE_W-1:0] dac_code_o,      // shown codes, channel A lowest
    output logic      [3:0]          shutdown_o,      // per-channel shutdown, A is bit 0
    output logic                     frame_taken_o    // pulse: frame decoded
);
    import qdac_pkg::*;

    localparam int FRAME_W = CODE_W + 4;
    localparam bit WIDE    = (CODE_W == `QDAC_WIDE_CODE_W);
    localparam int ALL_BIT = WIDE ? `QDAC_WIDE_ALL_BIT : `QDAC_NARROW_ALL_BIT;
    localparam int ONE_BIT = WIDE ? `QDAC_WIDE_ONE_BIT : `QDAC_NARROW_ONE_BIT;
    localparam int AHI_BIT = WIDE ? `QDAC_WIDE_AHI_BIT : `QDAC_NARROW_AHI_BIT;
    localparam int ALO_BIT = WIDE ? `QDAC_WIDE_ALO_BIT : `QDAC_NARROW_ALO_BIT;
    localparam logic [CODE_W-1:0] CODE_RST = CODE_W'(`QDAC_RESET_CODE);

    typedef struct packed {
        logic                   sel_prev;
        logic [3:0][CODE_W-1:0] in_code;
        logic [3:0][CODE_W-1:0] dac_code;
        logic [3:0]             shut;
        logic [3:0][CODE_W-1:0] out_code;
        logic [3:0]             shut_out;
        logic                   taken;
    } qdac_state_s;

    qdac_state_s r_reg;
    qdac_state_s r_next;

    logic [`QDAC_SHIFT_W-1:0] shift_w;
    logic [2:0]               pins_sync;
    logic                     sel_n_sync;
    logic                     load_n_sync;
    logic                     zero_n_sync;
    logic                     sel_rise;
    logic                     flag_all;
    logic                     flag_one;
    qdac_chan_t               addr_w;
    logic [CODE_W-1:0]        code_w;
    qdac_cmd_e                cmd_w;

    qdac_link u_link (
        .sclk_i      (sclk_i),
        .rst_n_i     (rst_n_i),
        .select_n_i  (select_n_i),
        .serial_in_i (serial_in_i),
        .shift_o     (shift_w)
    );

    // pins idle high, so the synchroniser resets high and no false edge appears
    qdac_sync2 #(
        .W       (3),
        .RST_VAL (`QDAC_PIN_IDLE)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({select_n_i, load_strobe_n_i, zero_reset_n_i}),
        .q_o     (pins_sync)
    );

    assign sel_n_sync  = pins_sync[2];
    assign load_n_sync = pins_sync[1];
    assign zero_n_sync = pins_sync[0];

    // shifter is frozen while select is high, so its word is safe to sample
    // three clk edges after select rises; the host's clock-to-select hold covers it
    assign sel_rise = sel_n_sync & ~r_reg.sel_prev;

    assign flag_all = shift_w[ALL_BIT];
    assign flag_one = shift_w[ONE_BIT];
    assign addr_w   = {shift_w[AHI_BIT], shift_w[ALO_BIT]};
    assign code_w   = shift_w[CODE_W-1:0];

    always_comb begin
        if (flag_all) begin
            cmd_w = QDAC_CMD_SHUT_ALL;
        end else if (flag_one) begin
            cmd_w = QDAC_CMD_SHUT_ONE;
        end else begin
            cmd_w = QDAC_CMD_LOAD;
        end
    end

    always_comb begin
        r_next          = r_reg;
        r_next.sel_prev = sel_n_sync;
        r_next.taken    = 1'b0;
        if (sel_rise) begin
            r_next.taken = 1'b1;
            unique case (cmd_w)
                QDAC_CMD_SHUT_ALL: begin
                    r_next.shut = 4'hf;
                end
                QDAC_CMD_SHUT_ONE: begin
                    r_next.shut[addr_w] = 1'b1;
                end
                QDAC_CMD_LOAD: begin
                    r_next.in_code[addr_w] = code_w;
                    r_next.shut[addr_w]    = 1'b0;
                end
            endcase
        end
        if (!zero_n_sync) begin
            r_next.in_code  = {4{CODE_RST}};
            r_next.dac_code = {4{CODE_RST}};
        end else if (!load_n_sync) begin
            r_next.dac_code = r_next.in_code;
        end
        for (int i = 0; i < 4; i++) begin
            // shutdown masks the output only; the code register keeps updating
            r_next.out_code[i] = r_next.shut[i] ? CODE_RST : r_next.dac_code[i];
        end
        r_next.shut_out = r_next.shut;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg          <= '0;
            r_reg.sel_prev <= 1'b1;
            r_reg.shut     <= `QDAC_RESET_SHUT;
            r_reg.shut_out <= `QDAC_RESET_SHUT;
        end else begin
            r_reg <= r_next;
        end
    end

    assign dac_code_o    = r_reg.out_code;
    assign shutdown_o    = r_reg.shut_out;
    assign frame_taken_o = r_reg.taken;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_select_edge;
        !sel_n_sync ##1 sel_n_sync;
    endsequence

    sequence s_load_frame;
        sel_rise && !flag_all && !flag_one && zero_n_sync;
    endsequence

    a_frame_taken: assert property (s_select_edge |=> r_reg.taken)
        else $error("select edge not taken");

    a_frame_load: assert property (s_load_frame |=>
        r_reg.in_code[$past(addr_w)] == $past(code_w))
        else $error("code not loaded to addressed channel");

    a_input_hold: assert property ((!sel_rise && zero_n_sync) |=> $stable(r_reg.in_code))
        else $error("input register moved without select edge");

    a_shut_all: assert property ((sel_rise && flag_all) |=> r_reg.shut == 4'hf)
        else $error("all-channel shutdown missed");

    a_shut_one: assert property ((sel_rise && !flag_all && flag_one) |=>
        r_reg.shut[$past(addr_w)] && $stable(r_reg.in_code))
        else $error("single-channel shutdown missed");

    a_zero_clear: assert property (!zero_n_sync |=>
        (r_reg.in_code == '0) && (r_reg.dac_code == '0) && (r_reg.out_code == '0))
        else $error("zero reset did not clear registers");

    a_dac_follow: assert property ((!load_n_sync && zero_n_sync) |=>
        r_reg.dac_code == r_reg.in_code)
        else $error("DAC registers not transparent");

    a_dac_latch: assert property ((load_n_sync && zero_n_sync) |=> $stable(r_reg.dac_code))
        else $error("DAC registers moved with strobe high");

    a_out_mask: assert property (r_reg.shut_out[0] |-> r_reg.out_code[0] == '0)
        else $error("shut channel shows a code");

    a_out_wake: assert property ((!r_reg.shut_out[1]) |-> r_reg.out_code[1] == r_reg.dac_code[1])
        else $error("awake channel does not show its code");
endmodule
`default_nettype wire

// *** sim/qdac_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module qdac_host (
    output logic sclk_o,      // link clock, also toggled outside frames by idle_clocks
    output logic select_n_o,  // frame select, active low
    output logic serial_in_o  // serial data, msb first
);
    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b1;
        serial_in_o = 1'b0;
    end

    // 15 ns link period, phase unrelated to the system clock
    task automatic send(input logic [15:0] f, input int n);
        #3.3;
        select_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_o = f[i];
            #7.5 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
        end
        #15 select_n_o = 1'b1;
        // released line must not keep showing the last bit
        serial_in_o = ~serial_in_o;
    endtask

    // clock and data toggling with select high must leave the shifter alone
    task automatic idle_clocks(input int n);
        #3.3;
        for (int i = 0; i < n; i++) begin
            serial_in_o = ~serial_in_o;
            #7.5 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/qdac_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module qdac_top_tb;
    localparam int CW = 12;
    logic            clk_i = 1'b0;
    logic            rst_n_i = 1'b0;
    logic            load_strobe_n_i = 1'b1;
    logic            zero_reset_n_i = 1'b1;
    wire logic       sclk_i;
    wire logic       select_n_i;
    wire logic       serial_in_i;
    logic [4*CW-1:0] dac_code_o;
    logic [3:0]      shutdown_o;
    logic            frame_taken_o;
    logic [39:0]     dac_code_n;
    logic [3:0]      shutdown_n;
    logic            taken_n;
    logic [CW-1:0]   in_reg [4] = '{default: '0};
    logic [CW-1:0]   dac [4] = '{default: '0};
    logic [3:0]      shut = 4'h0;
    int              failures = 0;
    int              total_checks = 0;
    int              cycles = 0;

    always #2.5 clk_i = ~clk_i;

    qdac_host host (.sclk_o(sclk_i), .select_n_o(select_n_i), .serial_in_o(serial_in_i));
    qdac_top #(.CODE_W(CW)) dut (.clk_i, .rst_n_i, .sclk_i, .select_n_i, .serial_in_i,
        .load_strobe_n_i, .zero_reset_n_i, .dac_code_o, .shutdown_o, .frame_taken_o);
    // narrow variant shares the link and pins, decodes 14-bit frames
    qdac_top #(.CODE_W(10)) dut_narrow (.clk_i, .rst_n_i, .sclk_i, .select_n_i, .serial_in_i,
        .load_strobe_n_i, .zero_reset_n_i, .dac_code_o(dac_code_n), .shutdown_o(shutdown_n),
        .frame_taken_o(taken_n));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // shut channels show zero while their DAC register keeps its code
    function automatic logic [4*CW-1:0] shown();
        logic [4*CW-1:0] v;
        v = '0;
        for (int c = 0; c < 4; c++) begin
            if (!shut[c]) v[c*CW +: CW] = dac[c];
        end
        return v;
    endfunction

    task automatic chk_out();
        chk("dac_code", 64'(dac_code_o), 64'(shown()));
        chk("shutdown", 64'(shutdown_o), 64'(shut));
    endtask

    task automatic frame(input logic sa, input logic sd, input logic [1:0] a,
                         input logic [CW-1:0] code);
        int n;
        n = 0;
        host.send({sa, sd, a, code}, CW + 4);
        while (frame_taken_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("frame_taken", 64'(frame_taken_o), 64'(1'b1));
        if (sa) shut = 4'hF;
        else if (sd) shut[a] = 1'b1;
        else begin
            in_reg[a] = code;
            shut[a] = 1'b0;
        end
        if (!load_strobe_n_i) dac = in_reg;
        repeat (5) @(negedge clk_i);
        chk_out();
    endtask

    task automatic strobe();
        load_strobe_n_i = 1'b0;
        repeat (5) @(negedge clk_i);
        dac = in_reg;
        chk_out();
        load_strobe_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
    endtask

    task automatic t_reset();
        chk_out();
        $display("test reset done");
    endtask

    task automatic t_load();
        logic [CW-1:0] codes [4];
        codes = '{12'hFFF, 12'h001, 12'h800, 12'h7FE};
        for (int c = 0; c < 4; c++) frame(1'b0, 1'b0, 2'(c), codes[c]);
        strobe();
        frame(1'b0, 1'b0, 2'd0, 12'h123);
        host.idle_clocks(8);
        chk("shifter", 64'(dut.shift_w), 64'(16'h0123));
        strobe();
        $display("test load done");
    endtask

    task automatic t_shut();
        frame(1'b0, 1'b1, 2'd2, 12'h000);
        frame(1'b1, 1'b0, 2'd1, 12'hABC);
        load_strobe_n_i = 1'b0;
        frame(1'b0, 1'b0, 2'd1, 12'h456);
        load_strobe_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
        $display("test shutdown done");
    endtask

    task automatic t_zero();
        zero_reset_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        in_reg = '{default: '0};
        dac = '{default: '0};
        chk_out();
        zero_reset_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        strobe();
        $display("test zero reset done");
    endtask

    // wide instance sees stale top bits here and is no longer compared
    task automatic t_narrow();
        int n;
        n = 0;
        load_strobe_n_i = 1'b0;
        host.send({2'b00, 2'b10, 10'h2A5}, 14);
        while (taken_n !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("narrow_taken", 64'(taken_n), 64'(1'b1));
        repeat (5) @(negedge clk_i);
        chk("narrow_code", 64'(dac_code_n[20 +: 10]), 64'(10'h2A5));
        chk("narrow_shut", 64'(shutdown_n[2]), 64'(1'b0));
        load_strobe_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
        host.send({2'b10, 2'b00, 10'h000}, 14);
        repeat (8) @(negedge clk_i);
        chk("narrow_all", 64'(shutdown_n), 64'(4'hF));
        $display("test narrow done");
    endtask

    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        t_reset();
        t_load();
        t_shut();
        t_zero();
        t_narrow();
        tally_and_finish();
    end
endmodule
`default_nettype wire
